/* File: core/audio_fmt_pkg.sv */
// Shared constants and format decoding for the serial audio link
package audio_fmt_pkg;

  // Register offsets
  localparam logic [7:0] WORD_FORMAT_ADDR = 8'h35;
  localparam logic [7:0] FRAME_CONTROL_ADDR = 8'h36;
  localparam logic [7:0] STATUS_ADDR = 8'h37;

  // Values after reset
  localparam logic [7:0] WORD_FORMAT_RESET = 8'h01;
  localparam logic [7:0] FRAME_CONTROL_RESET = 8'h01;

  // Field positions in the word format register
  localparam int FORMAT_LSB = 0;
  localparam int FORMAT_MSB = 2;
  // Field positions in the frame control register
  localparam int RIGHT_FIRST_BIT = 5;
  localparam int FRAME_SIZE_LSB = 3;
  localparam int FRAME_SIZE_MSB = 4;
  localparam int BIT_ORDER_BIT = 2;
  localparam int PAIR_POL_BIT = 1;
  localparam int EDGE_BIT = 0;
  // Field positions in the status register
  localparam int STICKY_BIT = 0;
  localparam int PENDING_BIT = 1;

  // Word format codes
  localparam logic [2:0] FMT_STANDARD = 3'h0;
  localparam logic [2:0] FMT_LEFT = 3'h1;
  localparam logic [2:0] FMT_RIGHT16 = 3'h4;
  localparam logic [2:0] FMT_RIGHT20 = 3'h5;
  localparam logic [2:0] FMT_RIGHT18 = 3'h6;
  localparam logic [2:0] FMT_RIGHT24 = 3'h7;

  // Frame size codes
  localparam logic [1:0] FRAME_64 = 2'h0;
  localparam logic [1:0] FRAME_48 = 2'h1;
  localparam logic [1:0] FRAME_32 = 2'h2;

  // Sample width carried on the parallel side, left aligned
  localparam int SAMPLE_WIDTH = 24;

  // Timing of the bit clock made by the source end
  localparam int SYSTEM_CLOCK_NS = 4;
  localparam int BIT_CLOCK_NS = 160;
  localparam int BIT_HALF_CYCLES = BIT_CLOCK_NS / (2 * SYSTEM_CLOCK_NS);

  // Bit-clock cycles in one half of a pair-select period
  function automatic logic [5:0] halfBits(input logic [1:0] code);
    logic [5:0] h;
    h = 6'h20;
    case (code)
      FRAME_48: h = 6'h18;
      FRAME_32: h = 6'h10;
      default: h = 6'h20;
    endcase
    return h;
  endfunction : halfBits

  // Number of sample bits carried in each half period
  function automatic logic [4:0] wordWidth(input logic [2:0] fmt, input logic [5:0] half);
    logic [5:0] w;
    w = half - 6'h01;
    case (fmt)
      FMT_LEFT: w = half;
      FMT_RIGHT16: w = 6'h10;
      FMT_RIGHT18: w = 6'h12;
      FMT_RIGHT20: w = 6'h14;
      FMT_RIGHT24: w = 6'h18;
      default: w = half - 6'h01;
    endcase
    if (w > 6'h18) begin
      w = 6'h18;
    end
    if (w > half) begin
      w = half;
    end
    return w[4:0];
  endfunction : wordWidth

  // Bit index within the half period where the word starts
  function automatic logic [5:0] wordStart(input logic [2:0] fmt, input logic [5:0] half);
    logic [5:0] s;
    s = 6'h01;
    if (fmt[2]) begin
      s = half - {1'b0, wordWidth(fmt, half)};
    end else if (fmt == FMT_LEFT) begin
      s = 6'h00;
    end
    return s;
  endfunction : wordStart

  // Bit position within a left-aligned sample for bit k of the word
  function automatic logic [4:0] bitPos(input logic lsbFirst, input logic [4:0] w,
                                       input logic [5:0] k);
    logic [5:0] p;
    p = lsbFirst ? (6'h18 - {1'b0, w} + k) : (6'h17 - k);
    return p[4:0];
  endfunction : bitPos

endpackage : audio_fmt_pkg

/* File: core/audio_link_if.sv */
// Serial audio link between the source end and the receiver end
`timescale 1ns/1ps
`default_nettype none
interface audio_link_if;
  logic bitClock;      // Serial bit clock, made by the source
  logic pairSelect;    // Word select, marks the two words of a pair
  logic serialAudioIn; // Serial sample data

  // Source end drives the link
  modport source_end (output bitClock, output pairSelect, output serialAudioIn);
  // Receiver end only listens
  modport receiver_end (input bitClock, input pairSelect, input serialAudioIn);
endinterface : audio_link_if
`default_nettype wire

/* File: core/audio_serial_receiver.sv */
// Receiver end: format registers, link capture and pair buffer
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module audio_serial_receiver
  import audio_fmt_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  audio_link_if.receiver_end link,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic pairValid,
  input wire logic pairReady,
  output logic [23:0] pairLeft,
  output logic [23:0] pairRight
);

  // Register state
  logic [7:0] wordFormat_q, wordFormat_d;     // Word format register
  logic [7:0] frameControl_q, frameControl_d; // Frame control register
  logic overrun_q, overrun_d;                 // Sticky: pair lost to a full buffer
  logic [7:0] rdData_q, rdData_d;             // Read data, one cycle after the strobe

  // Link synchroniser, bit order {bitClock, pairSelect, serialAudioIn}
  logic [2:0] sync1_q, sync2_q;
  logic sckLast_q;                            // Previous synchronised bit clock

  // Capture state
  logic lastWs_q, lastWs_d;                   // Select level at the last capture
  logic [5:0] idx_q, idx_d;                   // Bit index within the half period
  logic started_q, started_d;                 // A select change has been seen
  logic [23:0] acc_q, acc_d;                  // Word being assembled
  logic [23:0] firstWord_q, firstWord_d;      // First word of the pair
  logic firstValid_q, firstValid_d;           // First word held

  // Pair buffer
  logic [47:0] mem_q [2], mem_d [2];          // Two entries {left, right}
  logic wrPtr_q, wrPtr_d;
  logic rdPtr_q, rdPtr_d;
  logic [1:0] count_q, count_d;

  // Decoded configuration
  logic [2:0] fmt;
  logic [5:0] half;
  logic [4:0] width;
  logic [5:0] start;
  logic lsbFirst, pairPol, edgeSel, rightFirst;

  // Capture outputs toward the buffer, and the buffer pop
  logic push;
  logic [47:0] pushPair;
  logic pop;

  // Link signals after the two flops
  logic sck, ws, sd;
  assign sck = sync2_q[2];
  assign ws = sync2_q[1];
  assign sd = sync2_q[0];

  // Configuration decode
  always_comb begin
    fmt = wordFormat_q[FORMAT_MSB:FORMAT_LSB];
    half = halfBits(frameControl_q[FRAME_SIZE_MSB:FRAME_SIZE_LSB]);
    width = wordWidth(fmt, half);
    start = wordStart(fmt, half);
    lsbFirst = frameControl_q[BIT_ORDER_BIT];
    pairPol = frameControl_q[PAIR_POL_BIT];
    edgeSel = frameControl_q[EDGE_BIT];
    rightFirst = frameControl_q[RIGHT_FIRST_BIT];
  end

  // Register next values and read data
  always_comb begin
    wordFormat_d = wordFormat_q;
    frameControl_d = frameControl_q;
    overrun_d = overrun_q;
    rdData_d = 8'h00;
    if (regWrite) begin
      if (regAddr == WORD_FORMAT_ADDR) begin
        wordFormat_d = regWrData;
      end
      if (regAddr == FRAME_CONTROL_ADDR) begin
        frameControl_d = regWrData;
      end
      if (regAddr == STATUS_ADDR && regWrData[STICKY_BIT]) begin
        overrun_d = 1'b0;
      end
    end
    // A loss in the clearing cycle still sets the flag
    if (push && count_q == 2'h2) begin
      overrun_d = 1'b1;
    end
    if (regRead) begin
      case (regAddr)
        WORD_FORMAT_ADDR: rdData_d = wordFormat_q;
        FRAME_CONTROL_ADDR: rdData_d = frameControl_q;
        STATUS_ADDR: rdData_d = {6'h00, pairValid, overrun_q};
        default: rdData_d = 8'h00;
      endcase
    end
  end

  // Register flops
  always_ff @(posedge clock) begin
    if (reset) begin
      wordFormat_q <= WORD_FORMAT_RESET;
      frameControl_q <= FRAME_CONTROL_RESET;
      overrun_q <= 1'b0;
      rdData_q <= 8'h00;
    end else begin
      wordFormat_q <= wordFormat_d;
      frameControl_q <= frameControl_d;
      overrun_q <= overrun_d;
      rdData_q <= rdData_d;
    end
  end
  assign regRdData = rdData_q;

  // Two-flop synchroniser for the link pins, third flop for edge finding
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sckLast_q <= 1'b0;
    end else begin
      sync1_q <= {link.bitClock, link.pairSelect, link.serialAudioIn};
      sync2_q <= sync1_q;
      sckLast_q <= sync2_q[2];
    end
  end

  // Capture next values
  always_comb begin
    logic capture;
    logic [5:0] idxNow;
    logic [5:0] k;
    logic inWord;
    logic [23:0] word;
    capture = 1'b0;
    idxNow = 6'h00;
    k = 6'h00;
    inWord = 1'b0;
    word = 24'h000000;
    lastWs_d = lastWs_q;
    idx_d = idx_q;
    started_d = started_q;
    acc_d = acc_q;
    firstWord_d = firstWord_q;
    firstValid_d = firstValid_q;
    push = 1'b0;
    pushPair = {firstWord_q, acc_q};
    // Rising edge when the flag is set, falling edge when clear
    capture = edgeSel ? (sck && !sckLast_q) : (!sck && sckLast_q);
    if (capture) begin
      // Index restarts at every select change
      idxNow = (ws != lastWs_q) ? 6'h00 : ((idx_q == 6'h3f) ? idx_q : idx_q + 6'h01);
      if (ws != lastWs_q) begin
        started_d = 1'b1;
      end
      lastWs_d = ws;
      idx_d = idxNow;
      k = idxNow - start;
      inWord = started_d && idxNow >= start && idxNow < start + {1'b0, width};
      if (inWord) begin
        word = (k == 6'h00) ? 24'h000000 : acc_q;
        word[bitPos(lsbFirst, width, k)] = sd;
        acc_d = word;
        if (k == {1'b0, width} - 6'h01) begin
          if (ws == pairPol) begin
            firstWord_d = word;
            firstValid_d = 1'b1;
          end else if (firstValid_q) begin
            // Second word closes the pair
            push = 1'b1;
            firstValid_d = 1'b0;
            pushPair = rightFirst ? {word, firstWord_q} : {firstWord_q, word};
          end
        end
      end
    end
  end

  // Capture flops
  always_ff @(posedge clock) begin
    if (reset) begin
      lastWs_q <= 1'b0;
      idx_q <= 6'h00;
      started_q <= 1'b0;
      acc_q <= 24'h000000;
      firstWord_q <= 24'h000000;
      firstValid_q <= 1'b0;
    end else begin
      lastWs_q <= lastWs_d;
      idx_q <= idx_d;
      started_q <= started_d;
      acc_q <= acc_d;
      firstWord_q <= firstWord_d;
      firstValid_q <= firstValid_d;
    end
  end

  // Buffer next values; a push into a full buffer is dropped
  assign pop = pairValid && pairReady;
  always_comb begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push && count_q != 2'h2) begin
      mem_d[wrPtr_q] = pushPair;
      wrPtr_d = !wrPtr_q;
    end
    if (pop) begin
      rdPtr_d = !rdPtr_q;
    end
    count_d = count_q + 2'((push && count_q != 2'h2) ? 1 : 0) - 2'(pop ? 1 : 0);
  end

  // Buffer flops
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_q[0] <= 48'h000000000000;
      mem_q[1] <= 48'h000000000000;
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Parallel pair output from the buffer head
  assign pairValid = count_q != 2'h0;
  assign pairLeft = mem_q[rdPtr_q][47:24];
  assign pairRight = mem_q[rdPtr_q][23:0];

endmodule : audio_serial_receiver
`default_nettype wire

/* File: core/audio_serial_source.sv */
// Source end: makes the bit clock and sends sample pairs on the link
`timescale 1ns/1ps
`default_nettype none
module audio_serial_source
  import audio_fmt_pkg::*;
#(
  parameter int HALF_CYCLES = BIT_HALF_CYCLES
)
(
  input wire logic clock,
  input wire logic reset,
  audio_link_if.source_end link,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic pairValid,
  output logic pairReady,
  input wire logic [23:0] pairLeft,
  input wire logic [23:0] pairRight
);

  // Configuration mirror of the receiver's layout
  logic [7:0] wordFormat_q, wordFormat_d;
  logic [7:0] frameControl_q, frameControl_d;
  logic underrun_q, underrun_d;               // Sticky: frame sent with no pair
  logic [7:0] rdData_q, rdData_d;

  // Pair waiting for the next frame
  logic [47:0] pend_q, pend_d;
  logic pendValid_q, pendValid_d;

  // Link generation
  logic [7:0] div_q, div_d;                   // Half-period divider
  logic sck_q, sck_d, ws_q, ws_d, sd_q, sd_d;
  logic [5:0] g_q, g_d;                       // Bit index within the frame
  logic [47:0] frame_q, frame_d;              // {first, second} words being sent
  logic frameLoad;

  // Decoded configuration
  logic [2:0] fmt;
  logic [5:0] half;
  logic [4:0] width;
  logic [5:0] start;
  assign fmt = wordFormat_q[FORMAT_MSB:FORMAT_LSB];
  assign half = halfBits(frameControl_q[FRAME_SIZE_MSB:FRAME_SIZE_LSB]);
  assign width = wordWidth(fmt, half);
  assign start = wordStart(fmt, half);

  // Registers, read data and the pending pair
  always_comb begin
    wordFormat_d = wordFormat_q;
    frameControl_d = frameControl_q;
    underrun_d = underrun_q;
    rdData_d = 8'h00;
    pend_d = pend_q;
    pendValid_d = pendValid_q;
    if (regWrite) begin
      if (regAddr == WORD_FORMAT_ADDR) begin
        wordFormat_d = regWrData;
      end
      if (regAddr == FRAME_CONTROL_ADDR) begin
        frameControl_d = regWrData;
      end
      if (regAddr == STATUS_ADDR && regWrData[STICKY_BIT]) begin
        underrun_d = 1'b0;
      end
    end
    if (regRead) begin
      case (regAddr)
        WORD_FORMAT_ADDR: rdData_d = wordFormat_q;
        FRAME_CONTROL_ADDR: rdData_d = frameControl_q;
        STATUS_ADDR: rdData_d = {6'h00, pendValid_q, underrun_q};
        default: rdData_d = 8'h00;
      endcase
    end
    // Frame start takes the pending pair, or flags a gap
    if (frameLoad) begin
      pendValid_d = 1'b0;
      if (!pendValid_q) begin
        underrun_d = 1'b1;
      end
    end
    if (pairValid && pairReady) begin
      pend_d = {pairLeft, pairRight};
      pendValid_d = 1'b1;
    end
  end
  assign pairReady = !pendValid_q;

  // Register flops
  always_ff @(posedge clock) begin
    if (reset) begin
      wordFormat_q <= WORD_FORMAT_RESET;
      frameControl_q <= FRAME_CONTROL_RESET;
      underrun_q <= 1'b0;
      rdData_q <= 8'h00;
      pend_q <= 48'h000000000000;
      pendValid_q <= 1'b0;
    end else begin
      wordFormat_q <= wordFormat_d;
      frameControl_q <= frameControl_d;
      underrun_q <= underrun_d;
      rdData_q <= rdData_d;
      pend_q <= pend_d;
      pendValid_q <= pendValid_d;
    end
  end
  assign regRdData = rdData_q;

  // Bit clock divider and launch of data and select
  always_comb begin
    logic launch;
    logic slot;
    logic [5:0] i;
    logic [5:0] k;
    logic [23:0] word;
    launch = 1'b0;
    slot = 1'b0;
    i = 6'h00;
    k = 6'h00;
    word = 24'h000000;
    frameLoad = 1'b0;
    div_d = div_q + 8'h01;
    sck_d = sck_q;
    ws_d = ws_q;
    sd_d = sd_q;
    g_d = g_q;
    frame_d = frame_q;
    if (div_q == 8'(HALF_CYCLES - 1)) begin
      div_d = 8'h00;
      sck_d = !sck_q;
      // Launch on rising edge when the flag is clear, falling when set
      launch = frameControl_q[EDGE_BIT] ? sck_q : !sck_q;
    end
    if (launch) begin
      g_d = (g_q >= {half[4:0], 1'b0} - 6'h01) ? 6'h00 : g_q + 6'h01;
      if (g_d == 6'h00) begin
        frameLoad = 1'b1;
        // Left first when clear, right first when set
        if (!pendValid_q) begin
          frame_d = 48'h000000000000;
        end else if (frameControl_q[RIGHT_FIRST_BIT]) begin
          frame_d = {pend_q[23:0], pend_q[47:24]};
        end else begin
          frame_d = pend_q;
        end
      end
      slot = g_d >= half;
      i = slot ? g_d - half : g_d;
      ws_d = slot ? !frameControl_q[PAIR_POL_BIT] : frameControl_q[PAIR_POL_BIT];
      word = slot ? frame_d[23:0] : frame_d[47:24];
      k = i - start;
      sd_d = 1'b0;
      if (i >= start && i < start + {1'b0, width}) begin
        sd_d = word[bitPos(frameControl_q[BIT_ORDER_BIT], width, k)];
      end
    end
  end

  // Link flops; the index starts on the last bit so the first launch opens a frame
  always_ff @(posedge clock) begin
    if (reset) begin
      div_q <= 8'h00;
      sck_q <= 1'b0;
      ws_q <= 1'b0;
      sd_q <= 1'b0;
      g_q <= 6'h3f;
      frame_q <= 48'h000000000000;
    end else begin
      div_q <= div_d;
      sck_q <= sck_d;
      ws_q <= ws_d;
      sd_q <= sd_d;
      g_q <= g_d;
      frame_q <= frame_d;
    end
  end
  assign link.bitClock = sck_q;
  assign link.pairSelect = ws_q;
  assign link.serialAudioIn = sd_q;

endmodule : audio_serial_source
`default_nettype wire

/* File: testbench/audio_link_chk.sv */
// Checker on the link wires between the two ends
`timescale 1ns/1ps
`default_nettype none
module audio_link_chk #(
  parameter int HALF_CYCLES = 20
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic bitClock,
  input wire logic pairSelect,
  input wire logic serialAudioIn
);
  logic clkPrev_q, selPrev_q, clkSeen_q, selSeen_q, halfKnown_q, launchRise_q; // Wire history
  logic [6:0] run_q, edges_q, lastHalf_q; // Cycle and edge counts
  logic clkChg, selChg;
  assign clkChg = bitClock != clkPrev_q;
  assign selChg = pairSelect != selPrev_q;
  // Count clocks per bit-clock level and bit-clock edges per select half
  always_ff @(posedge clock) begin
    if (reset) begin
      {clkPrev_q, selPrev_q, clkSeen_q, selSeen_q, halfKnown_q, launchRise_q} <= 6'h00;
      {run_q, edges_q, lastHalf_q} <= 21'h0;
    end else begin
      clkPrev_q <= bitClock;
      selPrev_q <= pairSelect;
      clkSeen_q <= clkSeen_q | clkChg;
      run_q <= clkChg ? 7'h00 : run_q + 7'h01;
      edges_q <= selChg ? 7'h00 : edges_q + {6'h00, clkChg};
      if (selChg) begin
        selSeen_q <= 1'b1;
        launchRise_q <= bitClock;
        lastHalf_q <= edges_q;
        halfKnown_q <= selSeen_q;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence quietClock;
    $stable(bitClock)[*2];
  endsequence
  sequence holdSelect;
    $stable(pairSelect)[*3];
  endsequence
  reset_idle_a: assert property (disable iff (1'b0)
    reset |=> !bitClock && !pairSelect && !serialAudioIn) else $error("link busy in reset");
  clk_half_a: assert property (clkChg && clkSeen_q |-> run_q == HALF_CYCLES - 1)
    else $error("bit clock half period wrong");
  clk_quiet_a: assert property ($changed(bitClock) |=> quietClock)
    else $error("bit clock glitch");
  sel_launch_a: assert property ($changed(pairSelect) |-> $changed(bitClock))
    else $error("select moved off a bit clock edge");
  data_launch_a: assert property ($changed(serialAudioIn) |-> $changed(bitClock))
    else $error("data moved off a bit clock edge");
  data_dir_a: assert property ($changed(serialAudioIn) && selSeen_q
    |-> bitClock == launchRise_q) else $error("data moved on capture edge");
  half_size_a: assert property (selChg && selSeen_q
    |-> edges_q inside {7'h1f, 7'h2f, 7'h3f}) else $error("bad bit count per select half");
  half_equal_a: assert property (selChg && halfKnown_q |-> edges_q == lastHalf_q)
    else $error("select halves differ");
  sel_hold_a: assert property ($changed(pairSelect) |=> holdSelect)
    else $error("select glitch");
endmodule : audio_link_chk
`default_nettype wire

/* File: testbench/testbench.sv */
// Testbench joining the source end and the receiver end over one link
`timescale 1ns/1ps
`default_nettype none
module testbench
  import audio_fmt_pkg::*;
;
  localparam int HALF = 10; // Short bit clock keeps the run brief
  logic clock, reset, rxWr, rxRd, txWr, txRd, rxReady, txValid, txReady, rxValid, capOn;
  logic lastBck_q; // Bit clock one cycle ago
  logic [7:0] regAddr, regWrData, rxRdData, txRdData;
  logic [23:0] rxLeft, rxRight, txLeft, txRight;
  logic [47:0] rxq[$]; // Nonzero pairs popped from the receiver
  logic [1:0] wq[$]; // Select and data seen at each rising bit clock
  logic [10:0] cfgs[9] = '{11'h000, 11'h109, 11'h412, 11'h624, 11'h717, 11'h02b, 11'h137, 11'h608,
    11'h52c};
  int failCount, nChecks;
  audio_link_if link();
  audio_serial_receiver audio_serial_receiver_inst (.clock, .reset, .link, .regAddr, .regWrData,
    .regWrite(rxWr), .regRead(rxRd), .regRdData(rxRdData), .pairValid(rxValid),
    .pairReady(rxReady), .pairLeft(rxLeft), .pairRight(rxRight));
  audio_serial_source #(.HALF_CYCLES(HALF)) audio_serial_source_inst (.clock, .reset, .link,
    .regAddr, .regWrData, .regWrite(txWr), .regRead(txRd), .regRdData(txRdData),
    .pairValid(txValid), .pairReady(txReady), .pairLeft(txLeft), .pairRight(txRight));
  audio_link_chk #(.HALF_CYCLES(HALF)) audio_link_chk_inst (.clock, .reset,
    .bitClock(link.bitClock), .pairSelect(link.pairSelect), .serialAudioIn(link.serialAudioIn));
  // System clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Collect popped pairs and wire samples
  always @(posedge clock) begin
    lastBck_q <= link.bitClock;
    if (rxValid === 1'b1 && rxReady && {rxLeft, rxRight} !== 48'h0) rxq.push_back({rxLeft, rxRight});
    if (capOn && link.bitClock && !lastBck_q) wq.push_back({link.pairSelect, link.serialAudioIn});
  end
  task automatic report_and_stop();
    if (failCount == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic timed_out();
    failCount++;
    report_and_stop();
  endtask : timed_out
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check8
  task automatic check48(input logic [47:0] got, input logic [47:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check48
  // Sample pair number k
  function automatic logic [47:0] pat(input int k);
    return {24'h9c35a1 + 24'(k) * 24'h010203, 24'h6b1e47 + 24'(k) * 24'h020101};
  endfunction : pat
  // Sample bits that survive a format, left aligned
  function automatic logic [23:0] keep(input logic [2:0] f, input logic [7:0] c);
    int h, w;
    h = (c[4:3] == 2'h1) ? 24 : (c[4:3] == 2'h2) ? 16 : 32;
    w = (f == 3'h0) ? h - 1 : (f == 3'h1) ? h : (f == 3'h4) ? 16 : (f == 3'h5) ? 20 :
        (f == 3'h6) ? 18 : 24;
    w = (w > h) ? h : (w > 24) ? 24 : w;
    return ~(24'hffffff >> w);
  endfunction : keep
  task automatic do_reset(input logic rdy);
    @(posedge clock);
    reset <= 1'b1;
    txValid <= 1'b0;
    capOn <= 1'b0;
    rxReady <= rdy;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rxq.delete();
    wq.delete();
  endtask : do_reset
  // Write one register of both ends at once
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    {rxWr, txWr} <= 2'h3;
    @(posedge clock);
    {rxWr, txWr} <= 2'h0;
  endtask : reg_wr
  task automatic reg_rd(input logic src, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    {rxRd, txRd} <= {!src, src};
    @(posedge clock);
    {rxRd, txRd} <= 2'h0;
    @(posedge clock);
    check8(src ? txRdData : rxRdData, exp);
  endtask : reg_rd
  task automatic send_pair(input int k);
    int n;
    @(posedge clock);
    {txLeft, txRight} <= pat(k);
    txValid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (txReady !== 1'b1 && n < 4000);
    txValid <= 1'b0;
    if (n >= 4000) timed_out();
  endtask : send_pair
  // Reset values, read-write fields and an unmapped place on both ends
  task automatic reg_case();
    do_reset(1'b1);
    for (int s = 0; s < 2; s++) begin
      reg_rd(s[0], WORD_FORMAT_ADDR, 8'h01);
      reg_rd(s[0], FRAME_CONTROL_ADDR, 8'h01);
    end
    reg_wr(8'h38, 8'h5a);
    reg_wr(WORD_FORMAT_ADDR, 8'h06);
    for (int s = 0; s < 2; s++) begin
      reg_rd(s[0], 8'h38, 8'h00);
      reg_rd(s[0], WORD_FORMAT_ADDR, 8'h06);
    end
  endtask : reg_case
  // Right first, LSB first, select high first, rising capture, seen on the wire
  task automatic wire_case();
    int i, n;
    logic [23:0] w0, w1;
    logic [47:0] p;
    do_reset(1'b1);
    reg_wr(WORD_FORMAT_ADDR, 8'h00);
    reg_wr(FRAME_CONTROL_ADDR, 8'h27);
    capOn <= 1'b1;
    for (int k = 0; k < 4; k++) send_pair(5);
    p = pat(5);
    n = 0;
    i = 0;
    for (int j = 1; j < wq.size(); j++) begin
      if (wq[j][1] && !wq[j - 1][1]) begin
        if (n == 1) i = j;
        n++;
      end
    end
    for (int k = 0; k < 24; k++) begin
      w0[k] = wq[i + 1 + k][0];
      w1[k] = wq[i + 33 + k][0];
    end
    check8({6'h0, wq[i + 31][1], wq[i + 32][1]}, 8'h02);
    check48({w0, w1}, {p[23:0], p[47:24]});
  endtask : wire_case
  // Three pairs end to end under one format
  task automatic loop_case(input logic [2:0] f, input logic [7:0] c);
    logic [47:0] m;
    int n;
    do_reset(1'b1);
    reg_wr(WORD_FORMAT_ADDR, {5'h00, f});
    reg_wr(FRAME_CONTROL_ADDR, c);
    m = {keep(f, c), keep(f, c)};
    for (int k = 0; k < 4; k++) send_pair(k);
    n = 0;
    while (!(rxq.size() >= 3 && rxq[$] === (pat(3) & m)) && n < 6000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 6000) timed_out();
    for (int k = 1; k < 4; k++) check48(rxq[rxq.size() - 4 + k], pat(k) & m);
  endtask : loop_case
  // Receiver stalls: two pairs kept, later ones dropped and flagged
  task automatic overflow_case();
    int n;
    do_reset(1'b0);
    for (int k = 0; k < 6; k++) send_pair(k);
    reg_rd(1'b1, STATUS_ADDR, 8'h02);
    reg_rd(1'b0, STATUS_ADDR, 8'h03);
    reg_wr(STATUS_ADDR, 8'h01);
    reg_rd(1'b0, STATUS_ADDR, 8'h02);
    rxReady <= 1'b1;
    n = 0;
    while (rxq.size() < 2 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 4000) timed_out();
    if (rxq[0] === pat(0)) begin
      check48(rxq[1], pat(1));
    end else begin
      check48(rxq[0], pat(1));
      check48(rxq[1], pat(2));
    end
  endtask : overflow_case
  // Main sequence
  initial begin
    {reset, rxWr, rxRd, txWr, txRd, rxReady, txValid, capOn} = 8'h80;
    {regAddr, regWrData, txLeft, txRight} = 64'h0;
    failCount = 0;
    nChecks = 0;
    reg_case();
    wire_case();
    for (int i = 0; i < 9; i++) loop_case(cfgs[i][10:8], cfgs[i][7:0]);
    overflow_case();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
